// >>> verilog/pbvs_pkg.sv
// pbvs_pkg: constants and types for the receiver self-test status block.
// assumes every user of it runs on one 100 MHz core clock.
package pbvs_pkg;

  // ----------------------------------------------------------------
  // test modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PBVS_MODE_OFF  = 2'b00,              // normal traffic, verifier idle
    PBVS_MODE_BIST = 2'b01,              // built-in self-test pattern
    PBVS_MODE_PRBS = 2'b10,              // pseudo-random pattern
    PBVS_MODE_PIPE = 2'b11               // pipe mode, no offset cancel here
  } pbvs_mode_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int           CORE_CLK_MHZ    = 100;   // core clock rate
  localparam int           ERR_MIN_CYC     = 3;     // prbs error pulse floor, cycles
  localparam int           ERR_CNT_W       = 2;     // width of the pulse counter
  localparam logic [1:0]   ERR_CNT_LOAD    = 2'(ERR_MIN_CYC - 1); // high now plus two more
  localparam logic [1:0]   ERR_CNT_ZERO    = 2'h0;  // counter expired

  // ----------------------------------------------------------------
  // offset cancellation and calibration, counted in sampled clock edges
  // ----------------------------------------------------------------
  localparam int           TICK_CNT_W      = 5;     // width of both tick counters
  localparam logic [4:0]   OFFS_CAL_TICKS  = 5'h10; // reconfig edges per offset cancel
  localparam logic [4:0]   CAL_BLK_TICKS   = 5'h10; // cal clock edges per calibration
  localparam logic [4:0]   TICK_ONE        = 5'h01; // counter step

  // ----------------------------------------------------------------
  // reconfiguration return word layout
  // ----------------------------------------------------------------
  localparam int           RCFG_OFFS_BIT   = 0;     // offset cancellation finished
  localparam int           RCFG_CAL_BIT    = 1;     // calibration block ready
  localparam int           RCFG_STAT_W     = 2;     // status bits below the echo

endpackage : pbvs_pkg

// >>> verilog/pbvs_vfy_if.sv
// pbvs_vfy_if: verifier events in, status flags out, between the top and
// the flag keeper. assumes both ends share core_clk.
`timescale 1ns/1ns
`default_nettype none
interface pbvs_vfy_if;
  pbvs_pkg::pbvs_mode_t mode;        // active test mode
  logic                 cycle_done;  // verifier saw a full pattern cycle, pulse
  logic                 err_det;     // verifier saw a pattern error, pulse
  logic                 done;        // completion flag
  logic                 err;         // error flag

  // top drives events, reads flags
  modport src (output mode, output cycle_done, output err_det, input done, input err);
  // flag keeper reads events, drives flags
  modport flg (input mode, input cycle_done, input err_det, output done, output err);
endinterface : pbvs_vfy_if
`default_nettype wire

// >>> verilog/pbvs_flags.sv
// pbvs_flags: completion and error flags of the pattern verifier.
// assumes events are one-cycle pulses on core_clk; reset is the receiver
// pcs reset, asynchronous and active high.
`timescale 1ns/1ns
`default_nettype none
module pbvs_flags (
  input  wire logic core_clk,    // recovered parallel clock
  input  wire logic reset,       // receiver pcs reset
  pbvs_vfy_if.flg   vif          // events and flags
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                                done_r, done_nxt;       // completion
  logic                                err_r, err_nxt;         // error
  logic [pbvs_pkg::ERR_CNT_W-1:0]      cnt_r, cnt_nxt;         // pulse floor
  logic                                seq_err_r, seq_err_nxt; // error in this sequence
  logic                                clean_r, clean_nxt;     // a clean sequence passed

  // next values; only reset clears done, prbs err drops only after the floor and a clean sequence
  always_comb begin
    done_nxt    = done_r;
    err_nxt     = err_r;
    cnt_nxt     = cnt_r;
    seq_err_nxt = seq_err_r;
    clean_nxt   = clean_r;
    if (cnt_r != pbvs_pkg::ERR_CNT_ZERO) begin
      cnt_nxt = cnt_r - 2'h1;
    end
    case (vif.mode)
      pbvs_pkg::PBVS_MODE_BIST: begin
        // full cycle or error both end the test
        if (vif.cycle_done || vif.err_det) begin
          done_nxt = 1'b1;
        end
        if (vif.err_det) begin
          err_nxt = 1'b1;
        end
      end
      pbvs_pkg::PBVS_MODE_PRBS: begin
        if (vif.cycle_done) begin
          done_nxt = 1'b1;
        end
        if (vif.err_det) begin
          // an error landing on a boundary also taints the next sequence:
          // a slightly longer pulse, never a missed one
          err_nxt     = 1'b1;
          cnt_nxt     = pbvs_pkg::ERR_CNT_LOAD;
          seq_err_nxt = 1'b1;
          clean_nxt   = 1'b0;
        end else begin
          if (vif.cycle_done) begin
            seq_err_nxt = 1'b0;
            if (!seq_err_r && err_r) begin
              clean_nxt = 1'b1;
            end
          end
          // drop only after the floor and a clean sequence
          if (err_r && cnt_r == pbvs_pkg::ERR_CNT_ZERO && clean_r) begin
            err_nxt   = 1'b0;
            clean_nxt = 1'b0;
          end
        end
      end
      default: begin
        // flags hold in the other modes
      end
    endcase
  end

  // registers, cleared straight by the pcs reset
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      done_r    <= 1'b0;
      err_r     <= 1'b0;
      cnt_r     <= pbvs_pkg::ERR_CNT_ZERO;
      seq_err_r <= 1'b0;
      clean_r   <= 1'b0;
    end else begin
      done_r    <= done_nxt;
      err_r     <= err_nxt;
      cnt_r     <= cnt_nxt;
      seq_err_r <= seq_err_nxt;
      clean_r   <= clean_nxt;
    end
  end

  assign vif.done = done_r;
  assign vif.err  = err_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_bist_done_set: assert property (@(posedge core_clk) disable iff (reset)
    (vif.mode == pbvs_pkg::PBVS_MODE_BIST && (vif.cycle_done || vif.err_det)) |=> done_r)
    else $error("bist done not raised");
  chk_prbs_done_set: assert property (@(posedge core_clk) disable iff (reset)
    (vif.mode == pbvs_pkg::PBVS_MODE_PRBS && vif.cycle_done) |=> done_r[*3])
    else $error("prbs done not raised and held");
  chk_done_sticky: assert property (@(posedge core_clk) disable iff (reset)
    done_r |=> done_r)
    else $error("done dropped without reset");
  chk_bist_err_hold: assert property (@(posedge core_clk) disable iff (reset)
    (vif.mode == pbvs_pkg::PBVS_MODE_BIST && vif.err_det) |=> err_r[*4])
    else $error("bist error not held");
  chk_prbs_err_floor: assert property (@(posedge core_clk) disable iff (reset)
    (vif.mode == pbvs_pkg::PBVS_MODE_PRBS && vif.err_det) |=> err_r[*3])
    else $error("prbs error shorter than floor");
  chk_prbs_err_drop: assert property (@(posedge core_clk) disable iff (reset)
    (err_r && !err_nxt) |-> (clean_r && cnt_r == pbvs_pkg::ERR_CNT_ZERO))
    else $error("prbs error dropped before a clean sequence");
  chk_reset_clears: assert property (@(posedge core_clk)
    reset |-> (!done_r && !err_r))
    else $error("flags not cleared by reset");
  chk_release_low: assert property (@(posedge core_clk)
    $fell(reset) |-> (!done_r && !err_r && cnt_r == pbvs_pkg::ERR_CNT_ZERO))
    else $error("flags not low after reset release");

endmodule : pbvs_flags
`default_nettype wire

// >>> verilog/pbvs_top.sv
// pbvs_top: receiver self-test status, offset cancellation pacing,
// calibration block pacing and the reconfiguration return bus.
// assumes verifier events and mode come from core_clk logic; reconfig bus,
// reconfig clock, cal clock and cal power-down arrive from other domains.
//
// Behaviour
// - bist done on full cycle or error, sticky
// - prbs done on full cycle, sticky
// - bist error flag sticky until pcs reset
// - prbs error high at least three cycles, drops when clean
// - reconfig clock paces offset cancel, except pipe
// - reconfig bus in from controller, status back
// - cal clock paces calibration; power-down stops it
// - pcs reset clears verifier and both flags
// - pcs reset is asynchronous; power-down is synchronised through two flops
`timescale 1ns/1ns
`default_nettype none
module pbvs_top #(
  parameter int RCFG_IN_W  = 4,   // reconfiguration bus from the controller
  parameter int RCFG_OUT_W = 8    // reconfiguration bus back to the controller
) (
  input  wire logic                  core_clk,       // recovered parallel clock
  input  wire logic                  reset,          // receiver pcs reset
  input  wire logic [1:0]            test_mode,      // pbvs_mode_t code
  input  wire logic                  vfy_cycle_done, // full pattern cycle, pulse
  input  wire logic                  vfy_err_det,    // pattern error, pulse
  input  wire logic                  reconfig_clk,   // reconfiguration clock
  input  wire logic [RCFG_IN_W-1:0]  reconfig_in,    // from the controller
  output logic      [RCFG_OUT_W-1:0] reconfig_out,   // to the controller
  input  wire logic                  cal_clk,        // calibration block clock
  input  wire logic                  cal_powerdown,  // calibration power-down
  output logic                       test_done,      // completion flag
  output logic                       test_err,       // error flag
  output logic                       offs_cal_done,  // offset cancellation done
  output logic                       cal_ready       // calibration done, powered
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (RCFG_IN_W < 1 || RCFG_OUT_W < RCFG_IN_W + pbvs_pkg::RCFG_STAT_W) begin : g_bad_w
    $error("reconfig_out too narrow for status plus echo");
  end
  // a zero target is only met once the counter wraps, far later than meant
  if (pbvs_pkg::OFFS_CAL_TICKS == '0 || pbvs_pkg::CAL_BLK_TICKS == '0) begin : g_bad_tick
    $error("tick targets must be nonzero");
  end

  // ----------------------------------------------------------------
  // verifier flags
  // ----------------------------------------------------------------
  pbvs_vfy_if vif ();   // link to the flag keeper

  assign vif.mode       = pbvs_pkg::pbvs_mode_t'(test_mode);
  assign vif.cycle_done = vfy_cycle_done;
  assign vif.err_det    = vfy_err_det;

  pbvs_flags u_flags (
    .core_clk (core_clk),
    .reset    (reset),
    .vif      (vif)
  );

  // the flags are flops inside the keeper, so these stay glitch free
  assign test_done = vif.done;
  assign test_err  = vif.err;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  logic                 rck_m_r, rck_s_r, rck_d_r;  // reconfig clock stages
  logic                 cck_m_r, cck_s_r, cck_d_r;  // cal clock stages
  logic                 cpd_m_r, cpd_s_r;           // cal power-down stages
  logic [RCFG_IN_W-1:0] rin_m_r, rin_s_r;           // reconfig bus stages

  // two flops per crossing; edge detect only looks at second and third.
  // the bus is static while the controller holds it, so per-bit sync is enough
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rck_m_r <= 1'b0;
      rck_s_r <= 1'b0;
      rck_d_r <= 1'b0;
      cck_m_r <= 1'b0;
      cck_s_r <= 1'b0;
      cck_d_r <= 1'b0;
      cpd_m_r <= 1'b1;   // assume powered down until seen otherwise
      cpd_s_r <= 1'b1;
      rin_m_r <= '0;
      rin_s_r <= '0;
    end else begin
      rck_m_r <= reconfig_clk;
      rck_s_r <= rck_m_r;
      rck_d_r <= rck_s_r;
      cck_m_r <= cal_clk;
      cck_s_r <= cck_m_r;
      cck_d_r <= cck_s_r;
      cpd_m_r <= cal_powerdown;
      cpd_s_r <= cpd_m_r;
      rin_m_r <= reconfig_in;
      rin_s_r <= rin_m_r;
    end
  end

  // rising edge of a sampled slow clock
  function automatic logic pbvs_rise(input logic cur, input logic prev);
    pbvs_rise = cur && !prev;
  endfunction : pbvs_rise

  logic rck_tick;   // one reconfig clock edge seen
  logic cck_tick;   // one cal clock edge seen

  assign rck_tick = pbvs_rise(rck_s_r, rck_d_r);
  assign cck_tick = pbvs_rise(cck_s_r, cck_d_r);

  // ----------------------------------------------------------------
  // offset cancellation and calibration pacing
  // ----------------------------------------------------------------
  logic [pbvs_pkg::TICK_CNT_W-1:0] offs_cnt_r, offs_cnt_nxt;   // reconfig edges
  logic                            offs_done_r, offs_done_nxt; // cancel finished
  logic [pbvs_pkg::TICK_CNT_W-1:0] cal_cnt_r, cal_cnt_nxt;     // cal edges
  logic                            cal_rdy_r, cal_rdy_nxt;     // calibration done
  logic [RCFG_OUT_W-1:0]           rout_r, rout_nxt;           // return word

  // only edges of the sampled clocks advance the counters; the slow clocks
  // must stay well below half the core rate for no edge to be missed
  always_comb begin
    offs_cnt_nxt  = offs_cnt_r;
    offs_done_nxt = offs_done_r;
    cal_cnt_nxt   = cal_cnt_r;
    cal_rdy_nxt   = cal_rdy_r;
    // pipe mode cancels offsets elsewhere, so this pacing waits
    if (vif.mode != pbvs_pkg::PBVS_MODE_PIPE && rck_tick && !offs_done_r) begin
      offs_cnt_nxt = offs_cnt_r + pbvs_pkg::TICK_ONE;
      if (offs_cnt_nxt == pbvs_pkg::OFFS_CAL_TICKS) begin
        offs_done_nxt = 1'b1;
      end
    end
    if (cpd_s_r) begin
      // powered down: lose progress, restart on power-up
      cal_cnt_nxt = '0;
      cal_rdy_nxt = 1'b0;
    end else if (cck_tick && !cal_rdy_r) begin
      cal_cnt_nxt = cal_cnt_r + pbvs_pkg::TICK_ONE;
      if (cal_cnt_nxt == pbvs_pkg::CAL_BLK_TICKS) begin
        cal_rdy_nxt = 1'b1;
      end
    end
    // status low, echo of the controller word above it
    rout_nxt                          = '0;
    rout_nxt[pbvs_pkg::RCFG_OFFS_BIT] = offs_done_nxt;
    rout_nxt[pbvs_pkg::RCFG_CAL_BIT]  = cal_rdy_nxt;
    rout_nxt[pbvs_pkg::RCFG_STAT_W +: RCFG_IN_W] = rin_s_r;
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      offs_cnt_r  <= '0;
      offs_done_r <= 1'b0;
      cal_cnt_r   <= '0;
      cal_rdy_r   <= 1'b0;
      rout_r      <= '0;
    end else begin
      offs_cnt_r  <= offs_cnt_nxt;
      offs_done_r <= offs_done_nxt;
      cal_cnt_r   <= cal_cnt_nxt;
      cal_rdy_r   <= cal_rdy_nxt;
      rout_r      <= rout_nxt;
    end
  end

  assign offs_cal_done = offs_done_r;
  assign cal_ready     = cal_rdy_r;
  assign reconfig_out  = rout_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_pipe_offs_hold: assert property (@(posedge core_clk) disable iff (reset)
    (vif.mode == pbvs_pkg::PBVS_MODE_PIPE) |=> $stable(offs_cnt_r))
    else $error("offset counter moved in pipe mode");
  chk_cal_pd_stop: assert property (@(posedge core_clk) disable iff (reset)
    cpd_s_r |=> (cal_cnt_r == '0 && !cal_ready))
    else $error("calibration ran while powered down");
  chk_rcfg_echo: assert property (@(posedge core_clk) disable iff (reset)
    1'b1 |=> reconfig_out[pbvs_pkg::RCFG_STAT_W +: RCFG_IN_W] == $past(rin_s_r))
    else $error("reconfig echo wrong");

  // the pacing outputs are sticky, or cleared only by their own stop
  chk_offs_sticky: assert property (@(posedge core_clk) disable iff (reset)
    offs_cal_done |=> offs_cal_done)
    else $error("offset cancel done dropped without reset");
  chk_cal_rdy_hold: assert property (@(posedge core_clk) disable iff (reset)
    (cal_ready && !cpd_s_r) |=> cal_ready)
    else $error("calibration ready dropped while powered");

  // done only once the counter has seen the full number of edges
  chk_offs_target: assert property (@(posedge core_clk) disable iff (reset)
    $rose(offs_cal_done) |-> (offs_cnt_r == pbvs_pkg::OFFS_CAL_TICKS))
    else $error("offset cancel done before its edge count");
  chk_cal_target: assert property (@(posedge core_clk) disable iff (reset)
    $rose(cal_ready) |-> (cal_cnt_r == pbvs_pkg::CAL_BLK_TICKS))
    else $error("calibration ready before its edge count");

  // without a sampled reconfig edge the offset counter must not move,
  // so a glitch on the slow clock cannot shorten the cancel
  chk_offs_tick_only: assert property (@(posedge core_clk) disable iff (reset)
    !rck_tick |=> $stable(offs_cnt_r))
    else $error("offset counter moved without a reconfig edge");

  // power-down reaches the block through two flops, so ready falls within
  // three edges of the pin; a pulse shorter than a cycle may go unseen
  chk_pd_clears_rdy: assert property (@(posedge core_clk) disable iff (reset)
    $rose(cal_powerdown) |-> ##[1:3] !cal_ready)
    else $error("calibration ready outlived power-down");

  // bits above the echo carry nothing
  chk_rcfg_top_zero: assert property (@(posedge core_clk) disable iff (reset)
    (reconfig_out >> (pbvs_pkg::RCFG_STAT_W + RCFG_IN_W)) == '0)
    else $error("reconfig return bits above the echo not zero");

endmodule : pbvs_top
`default_nettype wire

// >>> tb/pbvs_ctrl_model.sv
// pbvs_ctrl_model: reconfiguration controller and calibration clock source
// facing the status block. assumes the bench calls its tasks one at a time.
`timescale 1ns/1ns
`default_nettype none
module pbvs_ctrl_model #(
  parameter int RCFG_IN_W = 4     // controller word width
) (
  output logic                 reconfig_clk,  // stands low between bursts
  output logic                 cal_clk,       // stands low between bursts
  output logic [RCFG_IN_W-1:0] reconfig_in    // controller word
);
  initial begin
    reconfig_clk = 1'b0;
    cal_clk      = 1'b0;
    reconfig_in  = '0;
  end

  // ----------------------------------------------------------------
  // bursts at 10 MHz, well under what the sampler can follow
  // ----------------------------------------------------------------
  task automatic rcfg_pulses(input int n);
    repeat (n) begin
      #50 reconfig_clk = ~reconfig_clk;
      #50 reconfig_clk = ~reconfig_clk;
    end
  endtask : rcfg_pulses

  task automatic cal_pulses(input int n);
    repeat (n) begin
      #50 cal_clk = ~cal_clk;
      #50 cal_clk = ~cal_clk;
    end
  endtask : cal_pulses

  // new controller word, a plain level change
  task automatic send_word(input logic [RCFG_IN_W-1:0] w);
    reconfig_in = w;
  endtask : send_word
endmodule : pbvs_ctrl_model
`default_nettype wire

// >>> tb/test_pbvs_top.sv
// test_pbvs_top: self-checking bench for the self-test status block.
// assumes a single 100 MHz core clock; flag results go through a note queue.
`timescale 1ns/1ns
`default_nettype none
module test_pbvs_top;
  typedef struct {int at; logic d; logic e;} pbvs_note_t; // expected flags
  logic       core_clk, reset, vfy_cycle_done, vfy_err_det, cal_powerdown;
  logic       reconfig_clk, cal_clk, test_done, test_err, offs_cal_done, cal_ready;
  logic [1:0] test_mode;
  logic [3:0] reconfig_in, w;
  logic [7:0] reconfig_out;
  pbvs_note_t notes[$];   // oldest expectation first
  int         cyc, errors, cmp_count, k, nb, nc, seed;

  pbvs_top pbvs_top_inst (.core_clk(core_clk), .reset(reset), .test_mode(test_mode),
    .vfy_cycle_done(vfy_cycle_done), .vfy_err_det(vfy_err_det),
    .reconfig_clk(reconfig_clk), .reconfig_in(reconfig_in), .reconfig_out(reconfig_out),
    .cal_clk(cal_clk), .cal_powerdown(cal_powerdown), .test_done(test_done),
    .test_err(test_err), .offs_cal_done(offs_cal_done), .cal_ready(cal_ready));
  pbvs_ctrl_model pbvs_ctrl_model_inst (.reconfig_clk(reconfig_clk), .cal_clk(cal_clk),
    .reconfig_in(reconfig_in));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // comparison and closing
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
    cmp_count++;
    if (g !== x) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", nm, x, g);
    end
  endtask : chk

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // monitor: 2 ns after each edge, settle every note that falls due
  initial begin
    pbvs_note_t n;
    forever begin
      @(posedge core_clk);
      #2;
      cyc++;
      while (notes.size() > 0 && notes[0].at <= cyc) begin
        n = notes.pop_front();
        chk("test_done", n.d, test_done);
        chk("test_err", n.e, test_err);
      end
    end
  end

  // one cycle of events, noting the flags expected after the sampling edge
  task automatic step(input logic c, input logic e, input logic dx, input logic ex);
    @(negedge core_clk);
    vfy_cycle_done = c;
    vfy_err_det    = e;
    notes.push_back('{cyc + 1, dx, ex});
  endtask : step

  task automatic idle(input int n, input logic dx, input logic ex);
    repeat (n) step(1'b0, 1'b0, dx, ex);
  endtask : idle

  // reset lands between edges to show it needs no clock; mode only moves here
  task automatic rst(input pbvs_pkg::pbvs_mode_t m);
    for (k = 0; k < 50 && notes.size() > 0; k++) @(negedge core_clk);
    if (notes.size() > 0) begin
      errors++;
      $display("unexpected note queue: expected empty, seen %0d", notes.size());
      notes.delete();
    end
    @(negedge core_clk);
    reset = 1'b1;
    test_mode      = m;
    vfy_cycle_done = 1'b0;
    vfy_err_det    = 1'b0;
    #1 chk("flags in reset", 8'h00, {test_done, test_err});
    chk("status in reset", 8'h00, {offs_cal_done, cal_ready});
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    idle(2, 1'b0, 1'b0);
  endtask : rst

  // bounded wait on offs_cal_done (0) or cal_ready (1)
  task automatic wait_bit(input int i, input logic v);
    for (k = 0; k < 40 && (i == 0 ? offs_cal_done : cal_ready) !== v; k++)
      @(negedge core_clk);
    chk("status bit", {7'h00, v}, {7'h00, (i == 0 ? offs_cal_done : cal_ready)});
  endtask : wait_bit

  // watchdog: a hang becomes a mismatch
  initial begin
    #900000;
    errors++;
    $display("unexpected run length: expected finish, seen timeout");
    summarize();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    test_mode = 2'h0;
    vfy_cycle_done = 1'b0;
    vfy_err_det = 1'b0;
    cal_powerdown = 1'b1;
    seed = $urandom(19808);
    // bist: an error sets both flags, which outlive further events
    rst(pbvs_pkg::PBVS_MODE_BIST);
    step(1'b0, 1'b1, 1'b1, 1'b1);
    idle(20, 1'b1, 1'b1);
    step(1'b1, 1'b0, 1'b1, 1'b1);
    idle(3, 1'b1, 1'b1);
    // bist: clean cycle first, error later
    rst(pbvs_pkg::PBVS_MODE_BIST);
    step(1'b1, 1'b0, 1'b1, 1'b0);
    idle(5, 1'b1, 1'b0);
    step(1'b0, 1'b1, 1'b1, 1'b1);
    idle(3, 1'b1, 1'b1);
    // prbs: dirty sequence, then a clean one drops the error flag
    rst(pbvs_pkg::PBVS_MODE_PRBS);
    step(1'b0, 1'b1, 1'b0, 1'b1);
    idle(3, 1'b0, 1'b1);
    step(1'b1, 1'b0, 1'b1, 1'b1);
    idle(3, 1'b1, 1'b1);
    step(1'b1, 1'b0, 1'b1, 1'b1);
    idle(4, 1'b1, 1'b0);
    // prbs: a one-cycle clean sequence cannot cut the three-cycle floor
    rst(pbvs_pkg::PBVS_MODE_PRBS);
    step(1'b0, 1'b1, 1'b0, 1'b1);
    step(1'b1, 1'b0, 1'b1, 1'b1);
    step(1'b1, 1'b0, 1'b1, 1'b1);
    idle(2, 1'b1, 1'b0);
    idle(3, 1'b1, 1'b0);
    // prbs: random back-to-back error bursts and clean lengths
    repeat (3) begin
      rst(pbvs_pkg::PBVS_MODE_PRBS);
      nb = 1 + $urandom % 4;
      nc = 2 + $urandom % 5;
      repeat (nb) step(1'b0, 1'b1, 1'b0, 1'b1);
      step(1'b1, 1'b0, 1'b1, 1'b1);
      idle(nc, 1'b1, 1'b1);
      step(1'b1, 1'b0, 1'b1, 1'b1);
      idle(3, 1'b1, 1'b0);
    end
    // off and pipe: verifier events leave the flags alone
    for (int i = 0; i < 2; i++) begin
      rst(i == 0 ? pbvs_pkg::PBVS_MODE_OFF : pbvs_pkg::PBVS_MODE_PIPE);
      step(1'b1, 1'b1, 1'b0, 1'b0);
      step(1'b0, 1'b1, 1'b0, 1'b0);
      repeat (4) step(1'($urandom), 1'($urandom), 1'b0, 1'b0);
      idle(2, 1'b0, 1'b0);
    end
    // pipe mode: reconfig edges do not pace offset cancellation
    pbvs_ctrl_model_inst.rcfg_pulses(16);
    repeat (10) @(negedge core_clk);
    chk("offs_cal_done", 8'h00, {7'h00, offs_cal_done});
    // bist mode: exactly sixteen reconfig edges finish it
    rst(pbvs_pkg::PBVS_MODE_BIST);
    pbvs_ctrl_model_inst.rcfg_pulses(15);
    repeat (10) @(negedge core_clk);
    chk("offs_cal_done", 8'h00, {7'h00, offs_cal_done});
    pbvs_ctrl_model_inst.rcfg_pulses(1);
    wait_bit(0, 1'b1);
    // controller words come back on the return bus
    repeat (3) begin
      w = 4'($urandom);
      pbvs_ctrl_model_inst.send_word(w);
      repeat (6) @(negedge core_clk);
      chk("reconfig_out", {2'h0, w, 2'h1}, reconfig_out);
    end
    // calibration paced by its clock, stopped by power-down
    cal_powerdown = 1'b0;
    repeat (4) @(negedge core_clk);
    pbvs_ctrl_model_inst.cal_pulses(15);
    repeat (10) @(negedge core_clk);
    chk("cal_ready", 8'h00, {7'h00, cal_ready});
    pbvs_ctrl_model_inst.cal_pulses(1);
    wait_bit(1, 1'b1);
    cal_powerdown = 1'b1;
    wait_bit(1, 1'b0);
    pbvs_ctrl_model_inst.cal_pulses(16);
    repeat (10) @(negedge core_clk);
    chk("cal_ready", 8'h00, {7'h00, cal_ready});
    rst(pbvs_pkg::PBVS_MODE_OFF);
    summarize();
  end
endmodule : test_pbvs_top
`default_nettype wire
